/* File: logic/stc_pkg.sv */
// Shared constants and types for the stepper chopper block
`default_nettype none
package stc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] STC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] STC_OSCDIV_OFS = 12'h004;
  localparam logic [11:0] STC_STATUS_OFS = 12'h008;
  localparam int          STC_CTRL_EN_BIT = 0;
  localparam logic        STC_CTRL_RST    = 1'b1;
  // 25 MHz core clock / 22 gives about 1.14 MHz, near the RC nominal
  localparam logic [7:0]  STC_OSCDIV_RST  = 8'h16;
  // ----------------------------------------------------------------
  // Chopper timing and levels
  // ----------------------------------------------------------------
  localparam logic [3:0]  STC_CHOP_LAST   = 4'hf;
  localparam logic [6:0]  STC_PCT_100     = 7'h64;
  localparam logic [6:0]  STC_PCT_71      = 7'h47;
  localparam logic [6:0]  STC_PCT_38      = 7'h26;
  localparam logic [6:0]  STC_PCT_0       = 7'h00;
  typedef enum logic [1:0] {ST_OFF, ST_CHARGE, ST_SLOW, ST_FAST} stc_state_e;
endpackage : stc_pkg
`default_nettype wire

/* File: logic/stc_osc.sv */
// Chop oscillator tick generator and divide-by-16 chopping period
`default_nettype none
module stc_osc #(
  parameter int DIV_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] tick_period,
  output logic                  osc_tick,
  output logic                  chop_start
);
  import stc_pkg::*;

  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic [3:0]       phase_q, phase_d;
  logic             tick_q, tick_d;
  logic             chop_q, chop_d;

  always_comb begin
    cnt_d   = cnt_q;
    phase_d = phase_q;
    tick_d  = 1'b0;
    chop_d  = 1'b0;
    if (!run) begin
      // Oscillator stopped in standby
      cnt_d   = '0;
      phase_d = '0;
    end else if (cnt_q + 1'b1 >= tick_period) begin
      cnt_d   = '0;
      tick_d  = 1'b1;
      phase_d = phase_q + 4'h1;
      chop_d  = (phase_q == STC_CHOP_LAST);
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      phase_q <= '0;
      tick_q  <= 1'b0;
      chop_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      tick_q  <= tick_d;
      chop_q  <= chop_d;
    end
  end

  assign osc_tick   = tick_q;
  assign chop_start = chop_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chop_after_sixteen_a: assert property (chop_start |-> osc_tick && $past(phase_q) == 4'hf)
    else $error("chop start not on sixteenth tick");
  osc_stops_a: assert property (!run |=> !osc_tick && !chop_start)
    else $error("oscillator ran in standby");
endmodule : stc_osc
`default_nettype wire

/* File: logic/stc_chan.sv */
// One bridge channel: level decode and chopper state machine
`default_nettype none
module stc_chan (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        chop_start,
  input  wire logic        standby_n,
  input  wire logic        drive_en,
  input  wire logic        direction,
  input  wire logic        level_sel0,
  input  wire logic        level_sel1,
  input  wire logic        current_trip,
  input  wire logic        below_mixed,
  output logic             high_side_first,
  output logic             high_side_second,
  output logic             low_side_first,
  output logic             low_side_second,
  output logic [6:0]       level_pct,
  output logic [1:0]       level_code,
  output stc_pkg::stc_state_e state
);
  import stc_pkg::*;

  stc_state_e st_q, st_d;
  logic [3:0] sw_q, sw_d; // hs1 hs2 ls1 ls2
  logic [6:0] pct_q, pct_d;
  logic [1:0] code;
  logic       active;

  assign code   = {level_sel0, level_sel1};
  assign active = standby_n && drive_en && (code != 2'b00);

  always_comb begin
    case (code)
      2'b11:   pct_d = STC_PCT_100;
      2'b10:   pct_d = STC_PCT_71;
      2'b01:   pct_d = STC_PCT_38;
      default: pct_d = STC_PCT_0;
    endcase
    st_d = st_q;
    if (!active) begin
      st_d = ST_OFF;
    end else begin
      case (st_q)
        ST_OFF:    if (chop_start) st_d = ST_CHARGE;
        // Charge overruns the period until the trip fires
        ST_CHARGE: if (current_trip) st_d = ST_FAST;
        // Fast decay overruns the period until the fixed threshold
        ST_FAST:   if (below_mixed) st_d = chop_start ? ST_CHARGE : ST_SLOW;
        default:   if (chop_start) st_d = ST_CHARGE;
      endcase
    end
    // Direction picks which diagonal charges; zero level ignores it
    case (st_d)
      ST_CHARGE: sw_d = direction ? 4'b1001 : 4'b0110;
      ST_SLOW:   sw_d = 4'b0011;
      ST_FAST:   sw_d = direction ? 4'b0110 : 4'b1001;
      default:   sw_d = 4'b0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_OFF;
      sw_q  <= 4'h0;
      pct_q <= STC_PCT_0;
    end else begin
      st_q  <= st_d;
      sw_q  <= sw_d;
      pct_q <= pct_d;
    end
  end

  assign {high_side_first, high_side_second, low_side_first, low_side_second} = sw_q;
  assign level_pct  = pct_q;
  assign level_code = code;
  assign state      = st_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  off_when_idle_a: assert property (!active |=> sw_q == 4'h0 && st_q == ST_OFF)
    else $error("bridge driven while idle");
  no_shoot_through_a: assert property (!(sw_q[3] && sw_q[1]) && !(sw_q[2] && sw_q[0]))
    else $error("half bridge shoot through");
  charge_extends_a: assert property (st_q == ST_CHARGE && !current_trip && active |=> st_q == ST_CHARGE)
    else $error("charge ended before trip");
  fast_extends_a: assert property (st_q == ST_FAST && !below_mixed && active |=> st_q == ST_FAST)
    else $error("fast decay ended early");
  level_decode_a: assert property (code == 2'b10 |=> pct_q == 7'h47)
    else $error("71 percent decode wrong");
  charge_polarity_a: assert property (st_q == ST_CHARGE && $past(direction) |-> sw_q == 4'b1001)
    else $error("positive charge diagonal wrong");
endmodule : stc_chan
`default_nettype wire

/* File: logic/stc_top.sv */
// Two-channel stepper chopper control with APB register slave
// What this block does
// - Each channel maps its two level selects to 100, 71, 38 or 0 percent.
// - Direction high drives the positive output high, low reverses, ignored at zero.
// - Standby low stops the oscillator and turns the bridge off.
// - The chopping period is the oscillator frequency divided by sixteen.
// - Current is held with only charge, slow-decay and fast-decay states.
// - Positive flow charges on first high and second low, slow on both low, fast reversed.
// - Negative flow charges on second high and first low, slow on both low, fast reversed.
// - Charge runs past the period boundary until the current trip fires.
// - The mixed-decay threshold is fixed and cannot be adjusted.
// - Fast decay runs past the period boundary until the mixed threshold is met.
// - The trip level is reference over five over sense resistance, scaled by level.
`default_nettype none
module stc_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // ----------------------------------------------------------------
  // Step controller inputs
  // ----------------------------------------------------------------
  input  wire logic        standby_n,
  input  wire logic        chan_a_direction,
  input  wire logic        chan_a_level_sel0,
  input  wire logic        chan_a_level_sel1,
  input  wire logic        chan_b_direction,
  input  wire logic        chan_b_level_sel0,
  input  wire logic        chan_b_level_sel1,
  // Comparator results from the sense front end
  input  wire logic        chan_a_current_trip,
  input  wire logic        chan_a_below_mixed,
  input  wire logic        chan_b_current_trip,
  input  wire logic        chan_b_below_mixed,
  // ----------------------------------------------------------------
  // Bridge drive and reference outputs
  // ----------------------------------------------------------------
  output logic             chan_a_high_side_first,
  output logic             chan_a_high_side_second,
  output logic             chan_a_low_side_first,
  output logic             chan_a_low_side_second,
  output logic             chan_b_high_side_first,
  output logic             chan_b_high_side_second,
  output logic             chan_b_low_side_first,
  output logic             chan_b_low_side_second,
  output logic [6:0]       chan_a_level_pct,
  output logic [6:0]       chan_b_level_pct,
  output logic             chop_oscillator,
  output logic             chop_period_start
);
  import stc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        drive_en_q, drive_en_d;
  logic [7:0]  osc_div_q, osc_div_d;
  logic [31:0] rdata_q, rdata_d;
  logic        hit;
  logic        wr_acc;
  logic        setup;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Channel vectors
  // ----------------------------------------------------------------
  logic [1:0]  dir_v, sel0_v, sel1_v, trip_v, mixed_v;
  logic [1:0]  hs1_v, hs2_v, ls1_v, ls2_v;
  logic [6:0]  pct_v [2];
  logic [1:0]  code_v [2];
  stc_state_e  st_v [2];
  logic        chop_start;
  logic        osc_tick;

  assign dir_v   = {chan_b_direction, chan_a_direction};
  assign sel0_v  = {chan_b_level_sel0, chan_a_level_sel0};
  assign sel1_v  = {chan_b_level_sel1, chan_a_level_sel1};
  assign trip_v  = {chan_b_current_trip, chan_a_current_trip};
  assign mixed_v = {chan_b_below_mixed, chan_a_below_mixed};

  // ----------------------------------------------------------------
  // Shared chopping clock
  // ----------------------------------------------------------------
  stc_osc #(
    .DIV_W (8)
  ) u_osc (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .run         (standby_n),
    .tick_period (osc_div_q),
    .osc_tick    (osc_tick),
    .chop_start  (chop_start)
  );

  // ----------------------------------------------------------------
  // Independent channel choppers
  // ----------------------------------------------------------------
  // Only chop_start, standby and drive_en_q are common, so one channel's overrun
  // never stretches the other.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    stc_chan u_chan (
      .core_clk         (core_clk),
      .rst_n            (rst_n),
      .chop_start       (chop_start),
      .standby_n        (standby_n),
      .drive_en         (drive_en_q),
      .direction        (dir_v[c]),
      .level_sel0       (sel0_v[c]),
      .level_sel1       (sel1_v[c]),
      .current_trip     (trip_v[c]),
      .below_mixed      (mixed_v[c]),
      .high_side_first  (hs1_v[c]),
      .high_side_second (hs2_v[c]),
      .low_side_first   (ls1_v[c]),
      .low_side_second  (ls2_v[c]),
      .level_pct        (pct_v[c]),
      .level_code       (code_v[c]),
      .state            (st_v[c])
    );
  end

  assign chan_a_high_side_first  = hs1_v[0];
  assign chan_a_high_side_second = hs2_v[0];
  assign chan_a_low_side_first   = ls1_v[0];
  assign chan_a_low_side_second  = ls2_v[0];
  assign chan_b_high_side_first  = hs1_v[1];
  assign chan_b_high_side_second = hs2_v[1];
  assign chan_b_low_side_first   = ls1_v[1];
  assign chan_b_low_side_second  = ls2_v[1];
  // Scaled reference for the sense comparator DAC
  assign chan_a_level_pct        = pct_v[0];
  assign chan_b_level_pct        = pct_v[1];
  assign chop_oscillator         = osc_tick;
  assign chop_period_start       = chop_start;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign status = {22'h0, drive_en_q, standby_n,
                   code_v[1], code_v[0], 2'(st_v[1]), 2'(st_v[0])};

  always_comb begin
    if (paddr == STC_CTRL_OFS) begin
      hit = 1'b1;
    end else if (paddr == STC_OSCDIV_OFS) begin
      hit = 1'b1;
    end else if (paddr == STC_STATUS_OFS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    drive_en_d = drive_en_q;
    osc_div_d  = osc_div_q;
    rdata_d    = rdata_q;
    if (wr_acc && paddr == STC_CTRL_OFS) begin
      drive_en_d = pwdata[STC_CTRL_EN_BIT];
    end else if (wr_acc && paddr == STC_OSCDIV_OFS) begin
      // Zero is stored as one; both values give a tick every core clock
      osc_div_d = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    end
    if (setup) begin
      if (paddr == STC_CTRL_OFS) begin
        rdata_d = {31'h0, drive_en_q};
      end else if (paddr == STC_OSCDIV_OFS) begin
        rdata_d = {24'h0, osc_div_q};
      end else if (paddr == STC_STATUS_OFS) begin
        rdata_d = status;
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_en_q <= STC_CTRL_RST;
      osc_div_q  <= STC_OSCDIV_RST;
      rdata_q    <= 32'h0;
    end else begin
      drive_en_q <= drive_en_d;
      osc_div_q  <= osc_div_d;
      rdata_q    <= rdata_d;
    end
  end

  // Zero wait state: read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence ctrl_write_s;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence

  ctrl_write_takes_a: assert property (ctrl_write_s |=> drive_en_q == $past(pwdata[0]))
    else $error("control write not applied");
  soft_disable_a: assert property ((ctrl_write_s and !pwdata[0]) ##1 1'b1 |=>
                                   !chan_a_high_side_first && !chan_b_low_side_first)
    else $error("bridge on after disable");
  standby_off_a: assert property (!standby_n ##1 !standby_n |-> {hs1_v, hs2_v, ls1_v, ls2_v} == 8'h0)
    else $error("bridge on in standby");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h00c |-> pslverr)
    else $error("no error on unmapped address");
endmodule : stc_top
`default_nettype wire

/* File: verif/stc_step_model.sv */
// Step controller model driving direction and level selects of both channels
`default_nettype none
module stc_step_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       supply_ok,
  input  wire logic [3:0] step,
  output logic            chan_a_direction,
  output logic            chan_a_level_sel0,
  output logic            chan_a_level_sel1,
  output logic            chan_b_direction,
  output logic            chan_b_level_sel0,
  output logic            chan_b_level_sel1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Quarter-step table, {direction, sel0, sel1}
  // ----------------------------------------------------------------
  // Don't-care direction rows drive low; channel b runs a quarter period apart
  localparam logic [2:0] A_TBL [16] = '{3'h6, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3,
                                        3'h2, 3'h1, 3'h0, 3'h5, 3'h6, 3'h7, 3'h7, 3'h7};
  localparam logic [2:0] B_TBL [16] = '{3'h6, 3'h7, 3'h7, 3'h7, 3'h6, 3'h5, 3'h0, 3'h1,
                                        3'h2, 3'h3, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h5};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {chan_a_direction, chan_a_level_sel0, chan_a_level_sel1} <= 3'h0;
      {chan_b_direction, chan_b_level_sel0, chan_b_level_sel1} <= 3'h0;
    end else begin
      // Levels stay low until the motor supply is valid
      {chan_a_direction, chan_a_level_sel0, chan_a_level_sel1} <=
        supply_ok ? A_TBL[step] : 3'h0;
      {chan_b_direction, chan_b_level_sel0, chan_b_level_sel1} <=
        supply_ok ? B_TBL[step] : 3'h0;
    end
  end
endmodule : stc_step_model
`default_nettype wire

/* File: verif/stc_top_tb_top.sv */
// Self-checking testbench for the stepper chopper block
`default_nettype none
module stc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, standby_n, supply_ok;
  logic        trip_a, below_a, trip_b, below_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, chop_oscillator, chop_period_start;
  logic [3:0]  step;
  wire  [3:0]  sw_a, sw_b;
  logic [6:0]  pct_a, pct_b;
  logic        dir_a, s0_a, s1_a, dir_b, s0_b, s1_b;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // ----------------------------------------------------------------
  // Instances and clock
  // ----------------------------------------------------------------
  stc_step_model stc_step_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .supply_ok(supply_ok), .step(step),
    .chan_a_direction(dir_a), .chan_a_level_sel0(s0_a), .chan_a_level_sel1(s1_a),
    .chan_b_direction(dir_b), .chan_b_level_sel0(s0_b), .chan_b_level_sel1(s1_b));
  stc_top stc_top_inst (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_n(standby_n), .chan_a_direction(dir_a), .chan_a_level_sel0(s0_a),
    .chan_a_level_sel1(s1_a), .chan_b_direction(dir_b), .chan_b_level_sel0(s0_b),
    .chan_b_level_sel1(s1_b), .chan_a_current_trip(trip_a), .chan_a_below_mixed(below_a),
    .chan_b_current_trip(trip_b), .chan_b_below_mixed(below_b),
    .chan_a_high_side_first(sw_a[3]), .chan_a_high_side_second(sw_a[2]),
    .chan_a_low_side_first(sw_a[1]), .chan_a_low_side_second(sw_a[0]),
    .chan_b_high_side_first(sw_b[3]), .chan_b_high_side_second(sw_b[2]),
    .chan_b_low_side_first(sw_b[1]), .chan_b_low_side_second(sw_b[0]),
    .chan_a_level_pct(pct_a), .chan_b_level_pct(pct_b),
    .chop_oscillator(chop_oscillator), .chop_period_start(chop_period_start));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  task automatic wait_chop;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (chop_period_start !== 1'b1 && n < 100);
    check(n < 100, 1'b1, "chop pulse seen");
  endtask : wait_chop
  function automatic logic [6:0] pct_of(input logic s0, input logic s1);
    case ({s0, s1})
      2'b11: return STC_PCT_100;
      2'b10: return STC_PCT_71;
      2'b01: return STC_PCT_38;
      default: return STC_PCT_0;
    endcase
  endfunction : pct_of
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs;
    logic [31:0] rd;
    logic        err;
    apb_xfer(STC_CTRL_OFS, 1'b0, 32'h0, rd, err);
    check(rd, 32'h1, "ctrl reset");
    apb_xfer(STC_OSCDIV_OFS, 1'b0, 32'h0, rd, err);
    check(rd, {24'h0, STC_OSCDIV_RST}, "oscdiv reset");
    // Short oscillator period keeps the chop walks brief
    apb_xfer(STC_OSCDIV_OFS, 1'b1, 32'h2, rd, err);
    apb_xfer(STC_OSCDIV_OFS, 1'b0, 32'h0, rd, err);
    check(rd, 32'h2, "oscdiv readback");
    apb_xfer(12'h00c, 1'b0, 32'h0, rd, err);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    $display("test_regs done");
  endtask : test_regs
  task automatic test_levels;
    @(posedge core_clk);
    step <= 4'hd;
    repeat (3) @(posedge core_clk);
    #1;
    check(pct_a, STC_PCT_0, "level before supply");
    @(posedge core_clk);
    supply_ok <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      step <= 4'(i);
      repeat (3) @(posedge core_clk);
      #1;
      check(pct_a, pct_of(s0_a, s1_a), "level a");
      check(pct_b, pct_of(s0_b, s1_b), "level b");
    end
    $display("test_levels done");
  endtask : test_levels
  task automatic chop_walk(input logic [3:0] st, input logic da, input logic db);
    logic [3:0] chg_a, fst_a, chg_b;
    chg_a = da ? 4'h9 : 4'h6;
    fst_a = da ? 4'h6 : 4'h9;
    chg_b = db ? 4'h9 : 4'h6;
    @(posedge core_clk);
    step <= st;
    // Two pulses so the new code has surely reached the chopper
    wait_chop;
    wait_chop;
    @(posedge core_clk);
    #1;
    check(sw_a, chg_a, "charge a");
    check(sw_b, chg_b, "charge b");
    wait_chop;
    @(posedge core_clk);
    #1;
    check(sw_a, chg_a, "charge held");
    @(posedge core_clk);
    trip_a <= 1'b1;
    @(posedge core_clk);
    trip_a <= 1'b0;
    #1;
    check(sw_a, fst_a, "fast decay");
    wait_chop;
    @(posedge core_clk);
    #1;
    check(sw_a, fst_a, "fast held");
    @(posedge core_clk);
    below_a <= 1'b1;
    @(posedge core_clk);
    below_a <= 1'b0;
    #1;
    check(sw_a, 4'h3, "slow decay");
    check(sw_b, chg_b, "b unaffected");
    wait_chop;
    @(posedge core_clk);
    #1;
    check(sw_a, chg_a, "recharge");
    $display("chop_walk done");
  endtask : chop_walk
  task automatic test_period;
    int ticks;
    int n;
    wait_chop;
    ticks = 0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      ticks += chop_oscillator;
      n++;
    end while (chop_period_start !== 1'b1 && n < 200);
    check(ticks, 16, "ticks per period");
    check(n, 32, "cycles per period");
    $display("test_period done");
  endtask : test_period
  task automatic test_off;
    int ticks;
    logic [31:0] rd;
    logic        err;
    // Software disable must drop both bridges, then re-enable
    apb_xfer(STC_CTRL_OFS, 1'b1, 32'h0, rd, err);
    repeat (2) @(posedge core_clk);
    #1;
    check({sw_a, sw_b}, 8'h0, "soft disable off");
    apb_xfer(STC_CTRL_OFS, 1'b1, 32'h1, rd, err);
    @(posedge core_clk);
    step <= 4'h2;
    wait_chop;
    wait_chop;
    @(posedge core_clk);
    #1;
    check(sw_a, 4'h0, "zero level off");
    check(sw_b, 4'h9, "b charging");
    @(posedge core_clk);
    standby_n <= 1'b0;
    @(posedge core_clk);
    ticks = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      ticks += chop_oscillator;
    end
    check(ticks, 0, "oscillator stopped");
    check({sw_a, sw_b}, 8'h0, "standby off");
    @(posedge core_clk);
    standby_n <= 1'b1;
    $display("test_off done");
  endtask : test_off
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, supply_ok} = 4'h0;
    {trip_a, below_a, trip_b, below_b} = 4'h0;
    standby_n = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    step = 4'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    test_regs;
    test_levels;
    chop_walk(4'hd, 1'b1, 1'b0);
    chop_walk(4'h5, 1'b0, 1'b1);
    test_period;
    test_off;
    test_done;
  end
endmodule : stc_top_tb_top
`default_nettype wire
